/* File: sotu_uart.sv */
`timescale 1ns/1ns
module sotu_uart
    import sotu_pkg::*;
#(
    parameter int unsigned RETRY_CYCLES = RETRY_CYC,
    parameter int unsigned RESTART_CYCLES = RESTART_CYC,
    parameter logic [EST_W-1:0] BIT_CYC_INIT = BIT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rx_wait,
    input wire logic fr0_wr,
    input wire logic [7:0] frame_buffer_first,
    input wire logic end_cmd,
    input wire logic passthrough_enable,
    input wire logic standard_io_select,
    input wire logic high_side_enable,
    input wire logic low_side_enable,
    input wire logic ss,
    input wire logic mosi,
    input wire logic spi_miso,
    input wire logic rx_octet_valid,
    input wire logic [7:0] rx_octet,
    input wire logic link_line_in,
    input wire logic short_detect,
    input wire logic overtemp_detect,
    output logic data_request_flag,
    output logic short_circuit_flag,
    output logic overtemperature_flag,
    output logic spi_freeze,
    output logic miso,
    output logic hs_drive,
    output logic ls_drive,
    output logic [EST_W-1:0] bit_period
);

    sotu_tx_e state_reg, state_next;
    sotu_sh_e sh_reg;
    logic [7:0] buf_reg;
    logic [10:0] shift_reg;
    logic [3:0] slot_reg;
    logic [EST_W-1:0] bit_cnt_reg, run_cnt_reg, run_len_reg, filt_depth;
    logic frame_active_reg, bit_tick, frame_done, frame_start;
    logic [7:0] load_data;
    logic line_q_reg, armed_reg, mosi_lat_reg, mosi_eff, want_high;
    logic hs_t, ls_t, hs_next, ls_next, fault, passive_link, line_filt;
    logic [15:0] short_cnt_reg, ok_cnt_reg;
    logic [31:0] off_cnt_reg;
    logic [2:0] trips_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Builds the logical frame, start bit first, with even parity over the data.
    function automatic logic [10:0] sotu_frame(input logic [7:0] d);
        return {1'b1, ^d, d, 1'b0};
    endfunction

    // Frame events of the shifter.
    assign bit_tick = frame_active_reg && (bit_cnt_reg == bit_period - EST_W'(1));
    assign frame_done = bit_tick && (slot_reg == SLOT_LAST);

    // A frame starts from the host octet, or from the buffer at the end of a frame.
    always_comb
    begin
        frame_start = 1'b0;
        load_data = frame_buffer_first;
        unique case (state_reg)
            TX_IDLE: frame_start = rx_wait && fr0_wr;
            TX_WAIT: frame_start = fr0_wr;
            TX_EMPTY: frame_start = fr0_wr && frame_done;
            TX_FULL:
            begin
                frame_start = frame_done;
                load_data = buf_reg;
            end
            TX_TERM: frame_start = 1'b0;
        endcase
    end

    // Next state of the transmit path.
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            TX_IDLE:
            begin
                if (rx_wait && fr0_wr)
                    state_next = TX_EMPTY;
            end
            TX_WAIT:
            begin
                if (fr0_wr)
                    state_next = TX_EMPTY;
                else if (end_cmd)
                    state_next = TX_IDLE;
            end
            TX_EMPTY:
            begin
                if (fr0_wr && !frame_done)
                    state_next = TX_FULL;
                else if (fr0_wr)
                    state_next = TX_EMPTY;
                else if (end_cmd && frame_done)
                    state_next = TX_IDLE;
                else if (end_cmd)
                    state_next = TX_TERM;
                else if (frame_done)
                    state_next = TX_WAIT;
            end
            TX_FULL:
            begin
                if (frame_done)
                    state_next = TX_EMPTY;
            end
            TX_TERM:
            begin
                if (frame_done)
                    state_next = TX_IDLE;
            end
        endcase
    end

    // State register; passthrough mode holds the transmit path in reset.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state_reg <= TX_IDLE;
        else if (passthrough_enable)
            state_reg <= TX_IDLE;
        else
            state_reg <= state_next;
    end

    // The request stands while the single buffer is empty in transmit wait or transmit empty, not in idle or terminate.
    assign data_request_flag = (state_reg == TX_WAIT) || (state_reg == TX_EMPTY);

    // Buffer write while the current octet is still shifting.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            buf_reg <= 8'h00;
        else if (state_reg == TX_EMPTY && fr0_wr && !passthrough_enable)
            buf_reg <= frame_buffer_first;
    end

    // Shifter: eleven frame bits and one idle gap bit per octet.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_active_reg <= 1'b0;
            shift_reg <= 11'h000;
            slot_reg <= 4'h0;
            bit_cnt_reg <= '0;
        end
        else if (passthrough_enable)
        begin
            frame_active_reg <= 1'b0;
        end
        else if (frame_start)
        begin
            frame_active_reg <= 1'b1;
            shift_reg <= sotu_frame(load_data);
            slot_reg <= 4'h0;
            bit_cnt_reg <= '0;
        end
        else if (bit_tick)
        begin
            bit_cnt_reg <= '0;
            shift_reg <= {1'b0, shift_reg[10:1]};
            if (slot_reg == SLOT_LAST)
                frame_active_reg <= 1'b0;
            else
                slot_reg <= slot_reg + 4'h1;
        end
        else if (frame_active_reg)
        begin
            bit_cnt_reg <= bit_cnt_reg + EST_W'(1);
        end
    end

    // Bit rate tracking from the first high run of each frame.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            line_q_reg <= 1'b0;
            armed_reg <= 1'b1;
            run_cnt_reg <= '0;
            run_len_reg <= '0;
            bit_period <= BIT_CYC_INIT;
        end
        else if (passthrough_enable)
        begin
            armed_reg <= 1'b1;
            run_cnt_reg <= '0;
            run_len_reg <= '0;
            bit_period <= BIT_CYC_INIT;
        end
        else
        begin
            line_q_reg <= link_line_in;
            if (!link_line_in)
                run_cnt_reg <= '0;
            else if (run_cnt_reg != '1)
                run_cnt_reg <= run_cnt_reg + EST_W'(1);
            if (line_q_reg && !link_line_in && armed_reg)
            begin
                run_len_reg <= run_cnt_reg;
                armed_reg <= 1'b0;
            end
            if (rx_octet_valid)
            begin
                armed_reg <= 1'b1;
                // Only an octet whose bit zero is one bounds the start bit alone.
                if (rx_octet[0] && run_len_reg != '0)
                    bit_period <= bit_period - (bit_period >> 2) + (run_len_reg >> 2);
            end
        end
    end

    // Latch of MOSI while select is high, frozen during an SPI access.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            mosi_lat_reg <= 1'b0;
        else if (ss)
            mosi_lat_reg <= mosi;
    end

    // Passthrough switch control from the MOSI level.
    assign mosi_eff = ss ? mosi : mosi_lat_reg;
    assign want_high = !mosi_eff;
    assign passive_link = passthrough_enable && !standard_io_select && !high_side_enable && !low_side_enable;
    always_comb
    begin
        if (standard_io_select)
        begin
            hs_t = high_side_enable && want_high;
            ls_t = low_side_enable && !want_high;
        end
        else
        begin
            hs_t = high_side_enable && low_side_enable && want_high;
            ls_t = high_side_enable && low_side_enable && !want_high;
        end
    end

    // Switch selection; a logic one is driven low and the gap bit is idle.
    assign fault = (sh_reg == SH_OFF) || overtemperature_flag;
    always_comb
    begin
        if (fault)
        begin
            hs_next = 1'b0;
            ls_next = 1'b0;
        end
        else if (passthrough_enable)
        begin
            hs_next = hs_t;
            ls_next = ls_t;
        end
        else if (frame_active_reg && slot_reg < SLOT_GAP)
        begin
            hs_next = !shift_reg[0];
            ls_next = shift_reg[0];
        end
        else
        begin
            hs_next = 1'b0;
            ls_next = 1'b0;
        end
    end

    // Registered switch outputs.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hs_drive <= 1'b0;
            ls_drive <= 1'b0;
        end
        else
        begin
            hs_drive <= hs_next;
            ls_drive <= ls_next;
        end
    end

    // Overtemperature status, monitored in every mode.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            overtemperature_flag <= 1'b0;
        else
            overtemperature_flag <= overtemp_detect;
    end

    // Short protection: detect, switch off, retry, restart and report.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sh_reg <= SH_DRIVE;
            short_cnt_reg <= 16'h0000;
            ok_cnt_reg <= 16'h0000;
            off_cnt_reg <= 32'h0000_0000;
            trips_reg <= 3'h0;
            short_circuit_flag <= 1'b0;
        end
        else if (passive_link)
        begin
            sh_reg <= SH_DRIVE;
            short_cnt_reg <= 16'h0000;
            ok_cnt_reg <= 16'h0000;
            off_cnt_reg <= 32'h0000_0000;
            trips_reg <= 3'h0;
            short_circuit_flag <= 1'b0;
        end
        else
        begin
            unique case (sh_reg)
                SH_DRIVE:
                begin
                    if (short_detect && (hs_drive || ls_drive))
                    begin
                        ok_cnt_reg <= 16'h0000;
                        if (short_cnt_reg == SHORT_CYC - 16'h0001)
                        begin
                            sh_reg <= SH_OFF;
                            short_cnt_reg <= 16'h0000;
                            if (trips_reg < RETRY_LIMIT)
                            begin
                                off_cnt_reg <= 32'(RETRY_CYCLES - 1);
                                trips_reg <= trips_reg + 3'h1;
                            end
                            else
                                off_cnt_reg <= 32'(RESTART_CYCLES - 1);
                            if (!(passthrough_enable && standard_io_select) || trips_reg >= RETRY_LIMIT - 3'h1)
                                short_circuit_flag <= 1'b1;
                        end
                        else
                            short_cnt_reg <= short_cnt_reg + 16'h0001;
                    end
                    else if (hs_drive || ls_drive)
                    begin
                        short_cnt_reg <= 16'h0000;
                        if (ok_cnt_reg == SHORT_CYC - 16'h0001)
                        begin
                            short_circuit_flag <= 1'b0;
                            trips_reg <= 3'h0;
                        end
                        else
                            ok_cnt_reg <= ok_cnt_reg + 16'h0001;
                    end
                end
                SH_OFF:
                begin
                    if (off_cnt_reg == 32'h0000_0000)
                        sh_reg <= SH_DRIVE;
                    else
                        off_cnt_reg <= off_cnt_reg - 32'h0000_0001;
                end
            endcase
        end
    end

    // Input path filter with a delay of one sixteenth of a bit period.
    assign filt_depth = ((bit_period >> FILT_SHIFT) == '0) ? EST_W'(1) : (bit_period >> FILT_SHIFT);
    sotu_glitch_filter #(
        .W(EST_W)
    ) u_filter (
        .clk(clk),
        .rst_b(rst_b),
        .din(link_line_in),
        .depth(filt_depth),
        .dout(line_filt)
    );

    // MISO selection between SPI data and the inverted filtered line.
    assign spi_freeze = passthrough_enable && ss;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            miso <= 1'b0;
        else if (passthrough_enable && ss)
            miso <= !line_filt;
        else
            miso <= spi_miso;
    end

    property p_start;
        state_reg == TX_IDLE && rx_wait && fr0_wr && !passthrough_enable
            |=> state_reg == TX_EMPTY && frame_active_reg && data_request_flag ##1 ls_drive == 1'b0 || fault;
    endproperty
    a_start: assert property (p_start) else $error("Host octet did not start a frame.");

    property p_full_no_request;
        state_reg == TX_FULL |-> !data_request_flag;
    endproperty
    a_full_no_request: assert property (p_full_no_request) else $error("Request raised with full buffer.");

    property p_fill;
        state_reg == TX_EMPTY && fr0_wr && !frame_done && !passthrough_enable |=> state_reg == TX_FULL;
    endproperty
    a_fill: assert property (p_fill) else $error("Buffer write did not fill the buffer.");

    property p_underrun;
        state_reg == TX_EMPTY && frame_done && !fr0_wr && !end_cmd && !passthrough_enable
            |=> state_reg == TX_WAIT && !frame_active_reg;
    endproperty
    a_underrun: assert property (p_underrun) else $error("Underrun did not reach transmit wait.");

    property p_term;
        state_reg == TX_TERM && frame_done && !passthrough_enable |=> state_reg == TX_IDLE ##1 !hs_drive && !ls_drive;
    endproperty
    a_term: assert property (p_term) else $error("Line not idle after terminating frame.");

    property p_gap;
        !passthrough_enable && frame_active_reg && slot_reg == SLOT_GAP |=> !hs_drive && !ls_drive;
    endproperty
    a_gap: assert property (p_gap) else $error("Line driven during gap bit.");

    property p_hold;
        passthrough_enable |=> state_reg == TX_IDLE && bit_period == BIT_CYC_INIT;
    endproperty
    a_hold: assert property (p_hold) else $error("Passthrough did not hold transmit logic.");

    property p_track;
        rx_octet_valid && !rx_octet[0] |=> $stable(bit_period);
    endproperty
    a_track: assert property (p_track) else $error("Edgeless octet moved the bit period.");

    property p_invert;
        passthrough_enable && ss && standard_io_select && high_side_enable && low_side_enable && !fault
            && $stable(passthrough_enable) |=> hs_drive == !$past(mosi);
    endproperty
    a_invert: assert property (p_invert) else $error("MOSI to line path not inverting.");

    property p_off;
        sh_reg == SH_OFF |=> !hs_drive && !ls_drive;
    endproperty
    a_off: assert property (p_off) else $error("Switches on during short.");

    property p_listen_clear;
        passive_link |=> !short_circuit_flag && sh_reg == SH_DRIVE;
    endproperty
    a_listen_clear: assert property (p_listen_clear) else $error("Passive link mode kept short state.");

endmodule

/* File: sotu_pkg.sv */
package sotu_pkg;

    // Clock and nominal line rate.
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned BAUD = 230_400;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

    // Width of the bit period estimate and its nominal value.
    localparam int unsigned EST_W = 16;
    localparam logic [EST_W-1:0] BIT_CYC = EST_W'(CLK_HZ / BAUD);

    // Frame layout: start, eight data bits, parity, stop, then an idle gap bit.
    localparam int unsigned FRAME_BITS = 11;
    localparam int unsigned GAP_BITS = 1;
    localparam logic [3:0] SLOT_LAST = 4'(FRAME_BITS + GAP_BITS - 1);
    localparam logic [3:0] SLOT_GAP = 4'(FRAME_BITS);

    // The input filter delay is the bit period shifted down by this amount.
    localparam int unsigned FILT_SHIFT = 4;

    // Short detect time and its count, rounded up.
    localparam int unsigned T_SHORT_NS = 10_000;
    localparam logic [15:0] SHORT_CYC = 16'((T_SHORT_NS * CYC_PER_US + 999) / 1000);

    // Retry and restart delays; the counts are top-level parameters.
    localparam int unsigned T_RETRY_US = 5_000;
    localparam int unsigned RETRY_CYC = T_RETRY_US * CYC_PER_US;
    localparam int unsigned T_RESTART_US = 50_000;
    localparam int unsigned RESTART_CYC = T_RESTART_US * CYC_PER_US;

    // Trips that use the retry delay before the restart delay; in standard IO operation a short is reported on the last of them.
    localparam logic [2:0] RETRY_LIMIT = 3'h3;

    // Transmit path states.
    typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_EMPTY, TX_FULL, TX_TERM} sotu_tx_e;

    // Short protection states.
    typedef enum logic {SH_DRIVE, SH_OFF} sotu_sh_e;

endpackage

/* File: sotu_glitch_filter.sv */
`timescale 1ns/1ns
module sotu_glitch_filter #(
    parameter int unsigned W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic din,
    input wire logic [W-1:0] depth,
    output logic dout
);

    logic [W-1:0] cnt_reg;

    // The output follows the input only after it has differed for depth cycles, a constant delay.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_reg <= '0;
            dout <= 1'b0;
        end
        else if (din == dout)
        begin
            cnt_reg <= '0;
        end
        else if (cnt_reg >= depth - W'(1))
        begin
            dout <= din;
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_reg + W'(1);
        end
    end

endmodule

/* File: sotu_link_master.sv */
`timescale 1ns/1ns
// Link master model: resolves the line from the device switches and its own drive.
module sotu_link_master (
    input wire logic hs_drive,
    input wire logic ls_drive,
    input wire logic master_en,
    input wire logic master_level,
    output logic link_line
);
    // Device switches win, then the master; a released line falls to its pull-down low level.
    assign link_line = hs_drive ? 1'b1 : ls_drive ? 1'b0 : master_en ? master_level : 1'b0;
endmodule

/* File: single_octet_tx_transparent_uart_bench.sv */
`timescale 1ns/1ns
module single_octet_tx_transparent_uart_bench;
    import sotu_pkg::*;
    localparam logic [EST_W-1:0] BP = 16'h0010;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic rx_wait = 0, fr0_wr = 0, end_cmd = 0, pt_en = 0, sio = 0, hs_en = 0, ls_en = 0, ss = 0, mosi = 0;
    logic spi_miso = 0, rx_v = 0, short_det = 0, ot_det = 0, m_en = 0, m_lvl = 0;
    logic [7:0] fb = 8'h00, rx_o = 8'h00;
    logic line, dreq, sc_flag, ot_flag, freeze, miso, hs, ls;
    logic [EST_W-1:0] bp;
    logic [7:0] oct [2];
    int err_count = 0, check_count = 0, cyc = 0, seed = 75639;

    // Design under test with shortened retry, restart and bit period counts.
    sotu_uart #(.RETRY_CYCLES(200), .RESTART_CYCLES(400), .BIT_CYC_INIT(BP)) i_dut (
        .clk(clk), .rst_b(rst_b), .rx_wait(rx_wait), .fr0_wr(fr0_wr), .frame_buffer_first(fb),
        .end_cmd(end_cmd), .passthrough_enable(pt_en), .standard_io_select(sio),
        .high_side_enable(hs_en), .low_side_enable(ls_en), .ss(ss), .mosi(mosi), .spi_miso(spi_miso),
        .rx_octet_valid(rx_v), .rx_octet(rx_o), .link_line_in(line), .short_detect(short_det),
        .overtemp_detect(ot_det), .data_request_flag(dreq), .short_circuit_flag(sc_flag),
        .overtemperature_flag(ot_flag), .spi_freeze(freeze), .miso(miso), .hs_drive(hs),
        .ls_drive(ls), .bit_period(bp));

    // Far side of the line.
    sotu_link_master i_master (.hs_drive(hs), .ls_drive(ls), .master_en(m_en), .master_level(m_lvl),
        .link_line(line));

    // Free running clock and the hang limit.
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            results();
        end
    end

    // Compares one value against its expectation.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Lets n rising edges pass and then steps just past the last one.
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Expected {high, low} switches in slot k of a frame carrying d; the gap slot drives nothing.
    function automatic logic [1:0] exp_sw(input logic [7:0] d, input int k);
        logic b;
        b = (k == 0) ? 1'b0 : (k < 9) ? d[k-1] : (k == 9) ? ^d : 1'b1;
        return (k == 11) ? 2'b00 : {~b, b};
    endfunction

    // Expected {high, low} switches in passthrough; mixed link settings drive nothing.
    function automatic logic [1:0] exp_pt(input logic s, input logic h, input logic l, input logic m);
        if (!s && (h != l))
            return 2'b00;
        return {h & ~m, l & m};
    endfunction

    // Main sequence of tests.
    initial
    begin
        void'($urandom(seed));
        step(16);
        rst_b = 1'b1;
        check(bp, BP, "reset bit period");
        for (int r = 0; r < 2; r++)
        begin
            oct[0] = (r == 0) ? 8'hFF : 8'($urandom);
            oct[1] = (r == 0) ? 8'h00 : 8'($urandom);
            rx_wait = 1;
            fr0_wr = 1;
            fb = oct[0];
            step(1);
            rx_wait = 0;
            check(dreq, 1, "request after start");
            fb = oct[1];
            step(1);
            fr0_wr = 0;
            check(dreq, 0, "buffer full");
            step(7);
            for (int k = 0; k < 24; k++)
            begin
                check({hs, ls}, exp_sw(oct[k / 12], k % 12), "frame slot");
                step(16);
            end
            check(dreq, 1, "transmit wait");
            end_cmd = 1;
            step(1);
            end_cmd = 0;
            step(1);
            check(dreq, 0, "end in wait");
        end
        $display("test transmit done");
        rx_wait = 1;
        fr0_wr = 1;
        fb = 8'($urandom);
        step(1);
        {rx_wait, fr0_wr, end_cmd} = 3'h1;
        step(1);
        end_cmd = 0;
        check(dreq, 0, "terminating");
        step(200);
        check({hs, ls}, 0, "idle after end");
        fr0_wr = 1;
        step(1);
        fr0_wr = 0;
        step(1);
        check(dreq, 0, "refused without receive wait");
        // An end command on the last cycle of a frame must not leave the path stuck.
        {rx_wait, fr0_wr} = 2'h3;
        step(1);
        {rx_wait, fr0_wr} = 2'h0;
        step(191);
        end_cmd = 1;
        step(1);
        end_cmd = 0;
        {rx_wait, fr0_wr} = 2'h3;
        step(1);
        {rx_wait, fr0_wr} = 2'h0;
        check(dreq, 1, "end on the last cycle of a frame");
        end_cmd = 1;
        step(1);
        end_cmd = 0;
        step(200);
        $display("test terminate done");
        {rx_wait, fr0_wr, ot_det} = 3'h7;
        step(1);
        {rx_wait, fr0_wr} = 2'h0;
        step(3);
        check(ot_flag, 1, "overtemperature flag");
        check({hs, ls}, 0, "switches off under fault");
        check(dreq, 1, "request under fault");
        end_cmd = 1;
        step(1);
        {end_cmd, ot_det} = 2'h0;
        step(200);
        $display("test fault done");
        rx_v = 1;
        step(1);
        rx_v = 0;
        step(2);
        check(bp, BP, "edgeless octet");
        rx_o = 8'hAA;
        rx_v = 1;
        step(1);
        rx_v = 0;
        // A 24 cycle start run, then an octet with bit zero set, pulls the estimate a quarter of the way.
        {m_en, m_lvl} = 2'h3;
        step(24);
        m_lvl = 0;
        step(1);
        {rx_v, rx_o} = 9'h155;
        step(1);
        {rx_v, m_en} = 2'h0;
        check(bp, BP - (BP >> 2) + 16'h0006, "rate follows a start bit run");
        $display("test tracking done");
        mosi = 1;
        pt_en = 1;
        step(1);
        ss = 1;
        for (int i = 0; i < 16; i++)
        begin
            {sio, hs_en, ls_en, mosi} = 4'(i);
            step(3);
            check({hs, ls}, exp_pt(sio, hs_en, ls_en, mosi), "passthrough switches");
            check(freeze, 1, "spi frozen");
        end
        {sio, hs_en, ls_en, mosi, rx_wait, fr0_wr} = 6'h1B;
        step(1);
        {rx_wait, fr0_wr} = 2'h0;
        step(2);
        check(dreq, 0, "transmit held in reset");
        check(bp, BP, "tracker held in reset");
        check({hs, ls}, 2'h2, "inverting path");
        ss = 0;
        mosi = 1;
        step(3);
        check({hs, ls}, 2'h2, "latched level while selected");
        {mosi, hs_en, ls_en, m_en, m_lvl} = {4'h1, 1'($urandom)};
        ss = 1;
        step(4);
        check(miso, !m_lvl, "filtered inverted line");
        ss = 0;
        spi_miso = 1'($urandom);
        step(2);
        check(miso, spi_miso, "spi data out");
        $display("test passthrough done");
        {hs_en, ls_en, mosi, m_en, ss, short_det, ot_det} = 7'h6E;
        step(1260);
        check(sc_flag, 1, "short at once in link mode");
        check({hs, ls}, 0, "switches off while short");
        step(200);
        check(hs, 1, "retry drive");
        ot_det = 1;
        step(2);
        check(ot_flag, 1, "monitoring in passthrough");
        {hs_en, ls_en, short_det, ot_det} = 4'h0;
        step(2);
        check(sc_flag, 0, "passive link clears short");
        // Standard IO high side into a short: silent on the first trips, reported on the third.
        {sio, hs_en, short_det} = 3'h7;
        step(1260);
        check(sc_flag, 0, "no report on first standard io trip");
        check({hs, ls}, 0, "switches off during retry");
        step(2900);
        check(sc_flag, 1, "report after retries in standard io");
        $display("test short done");
        results();
    end
endmodule
